// File: ext_irq_edge_detect.sv
// What this block does
// - Configured edge latches channel pending flag
// - Write one clears flag, zero keeps
// - Flag reads 1 pending, 0 idle
// - Bit k is channel k; above zero
// - Filter enable inserts noise filter
// - Sampling enable evaluates only at ticks
// - Sampling tick is 16 kHz time base
// - Mode 00 disables request generation
// - 01 falling, 10 rising, 11 both
// - Stop mode: no tick, no sampling
// - Control nibble per channel: mode, sample, filter
// - Select: port high nibble, pin low
// - Select register packs channels 3..0
// - Reset clears all config and flags
`timescale 1ns/100ps
`include "ext_irq_defines.svh"

module ext_irq_edge_detect #(
  parameter int PORT_COUNT = `EXT_IRQ_PORT_COUNT,
  parameter int PINS_PER_PORT = `EXT_IRQ_PINS_PER_PORT,
  parameter int FILTER_CYCLES = `EXT_IRQ_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Port pins, port p pin m at index p*PINS_PER_PORT+m
  input wire logic [PORT_COUNT*PINS_PER_PORT-1:0] portPins,
  // Fixed sources for channels 4 to 7
  input wire logic [3:0] upperChannelPins,
  // Time base and power state
  input wire logic lowSpeedSamplingTick,
  input wire logic stopMode,
  // Interrupt requests
  output logic [7:0] channelRequestFlags,
  output logic irq
);

  localparam int CHANNELS = 8;
  localparam int PIN_COUNT = PORT_COUNT * PINS_PER_PORT;
  localparam int SEL_CHANNELS = 4;
  localparam int IDX_W = $clog2(PIN_COUNT);

  // Bus state
  ext_irq_pkg::bus_state_t busState_q;
  ext_irq_pkg::bus_state_t busState_d;
  logic [31:0] readData_q;
  logic waitRequest_q;

  // Software registers
  logic [7:0] pending_q;
  logic [7:0] pending_d;
  logic [31:0] control_q;
  logic [31:0] pinSelect_q;
  logic [7:0] eventStatus_q;
  logic [7:0] eventStatus_d;
  logic [7:0] eventMask_q;
  logic irq_q;

  // Pin synchronisers
  logic [PIN_COUNT-1:0] pinMeta_q;
  logic [PIN_COUNT-1:0] pinSync_q;
  logic [3:0] upperMeta_q;
  logic [3:0] upperSync_q;

  // Channel signals
  logic [CHANNELS-1:0] chanLevel;
  logic [CHANNELS-1:0] edgeHit;
  logic effectiveTick;

  // Decode
  logic request;
  logic commit;
  logic writeCommit;
  logic readCommit;
  logic hitPending;
  logic hitControl;
  logic hitPinSel;
  logic hitEvtStatus;
  logic hitEvtMask;
  logic hitLevels;
  logic [31:0] byteMask;
  logic [31:0] readMux;
  logic [7:0] pendingClear;
  logic [7:0] eventClear;
  logic writeControl;
  logic writePinSel;
  logic writeMask;
  logic captureRead;
  logic [31:0] control_d;
  logic [31:0] pinSelect_d;
  logic [7:0] eventMask_d;
  logic [31:0] readData_d;
  logic waitRequest_d;
  logic irq_d;

  function automatic logic [31:0] mergeBytes(
    input logic [31:0] oldValue,
    input logic [31:0] newValue,
    input logic [31:0] mask
  );
    mergeBytes = (oldValue & ~mask) | (newValue & mask);
  endfunction

  // Two flip-flops on every asynchronous pin before any selection
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      upperMeta_q <= 4'h0;
      upperSync_q <= 4'h0;
    end
    else
    begin
      pinMeta_q <= portPins;
      pinSync_q <= pinMeta_q;
      upperMeta_q <= upperChannelPins;
      upperSync_q <= upperMeta_q;
    end
  end

  // The tick stops with the low-speed clock in stop mode
  assign effectiveTick = lowSpeedSamplingTick & ~stopMode;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      if (ch < SEL_CHANNELS)
      begin : g_sel
        wire [7:0] selField = pinSelect_q[ch*`EXT_IRQ_SEL_WIDTH +: `EXT_IRQ_SEL_WIDTH];
        wire [3:0] portNum = selField[`EXT_IRQ_SEL_PORT_MSB:`EXT_IRQ_SEL_PORT_LSB];
        wire [3:0] pinNum = selField[`EXT_IRQ_SEL_PIN_MSB:`EXT_IRQ_SEL_PIN_LSB];
        wire selValid = (32'(portNum) < PORT_COUNT) && (32'(pinNum) < PINS_PER_PORT);
        wire [IDX_W-1:0] pinIndex = IDX_W'(32'(portNum) * PINS_PER_PORT + 32'(pinNum));
        // Prohibited selections read as a quiet low input
        assign chanLevel[ch] = selValid ? pinSync_q[pinIndex] : 1'b0;
      end
      else
      begin : g_fixed
        assign chanLevel[ch] = upperSync_q[ch-SEL_CHANNELS];
      end

      ext_irq_channel #(
        .FILTER_CYCLES(FILTER_CYCLES)
      ) u_channel (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .levelIn(chanLevel[ch]),
        .samplingTick(effectiveTick),
        .filterEnable(control_q[ch*`EXT_IRQ_CTL_STRIDE + `EXT_IRQ_CTL_FILTER_BIT]),
        .samplingEnable(control_q[ch*`EXT_IRQ_CTL_STRIDE + `EXT_IRQ_CTL_SAMPLE_BIT]),
        .edgeMode(control_q[ch*`EXT_IRQ_CTL_STRIDE + `EXT_IRQ_CTL_MODE_LSB +: 2]),
        .edgeDetected(edgeHit[ch])
      );
    end
  endgenerate

  // Bus decode: waitrequest drops one cycle after a request is seen
  assign request = read | write;
  assign commit = request & (busState_q == ext_irq_pkg::BusAnswer);
  assign writeCommit = commit & write;
  assign readCommit = commit & read;

  assign hitPending = (address == `EXT_IRQ_OFS_PENDING);
  assign hitControl = (address == `EXT_IRQ_OFS_CONTROL);
  assign hitPinSel = (address == `EXT_IRQ_OFS_PIN_SEL);
  assign hitEvtStatus = (address == `EXT_IRQ_OFS_EVT_STATUS);
  assign hitEvtMask = (address == `EXT_IRQ_OFS_EVT_MASK);
  assign hitLevels = (address == `EXT_IRQ_OFS_LEVELS);

  assign byteMask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};

  // Unmapped addresses read zero; upper status bits always zero
  assign readMux = hitPending ? {24'h00_0000, pending_q} :
                   hitControl ? control_q :
                   hitPinSel ? pinSelect_q :
                   hitEvtStatus ? {24'h00_0000, eventStatus_q} :
                   hitEvtMask ? {24'h00_0000, eventMask_q} :
                   hitLevels ? {24'h00_0000, chanLevel} :
                   32'h0000_0000;

  // Only flags actually written with one are cleared
  assign pendingClear = (writeCommit & hitPending) ? (writedata[7:0] & byteMask[7:0]) : 8'h00;
  // Read clear covers only bits the master was shown, so later events survive
  assign eventClear = (readCommit & hitEvtStatus) ? readData_q[7:0] : 8'h00;

  assign pending_d = (pending_q & ~pendingClear) | edgeHit;
  assign eventStatus_d = (eventStatus_q & ~eventClear) | edgeHit;

  // Per-register write strobes, qualified by the completing edge
  assign writeControl = writeCommit & hitControl;
  assign writePinSel = writeCommit & hitPinSel;
  assign writeMask = writeCommit & hitEvtMask & byteenable[0];

  assign control_d = writeControl ? mergeBytes(control_q, writedata, byteMask) : control_q;
  assign pinSelect_d = writePinSel ? mergeBytes(pinSelect_q, writedata, byteMask) : pinSelect_q;
  assign eventMask_d = writeMask ? writedata[7:0] : eventMask_q;

  // Read data is taken when the request is first seen, so it stands through the answer cycle
  assign captureRead = request & (busState_q == ext_irq_pkg::BusIdle);
  assign readData_d = captureRead ? (read ? readMux : 32'h0000_0000) : readData_q;
  assign waitRequest_d = (busState_d != ext_irq_pkg::BusAnswer);

  // Interrupt and flag outputs are registered copies of next state
  assign irq_d = |(eventStatus_d & eventMask_q);

  always_comb
  begin
    case (busState_q)
      ext_irq_pkg::BusIdle: busState_d = request ? ext_irq_pkg::BusAnswer : ext_irq_pkg::BusIdle;
      ext_irq_pkg::BusAnswer: busState_d = ext_irq_pkg::BusIdle;
      default: busState_d = ext_irq_pkg::BusIdle;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busState_q <= ext_irq_pkg::BusIdle;
    end
    else
    begin
      busState_q <= busState_d;
    end
  end

  // Held high in reset so no master sees an answer before the block is running
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitRequest_q <= 1'b1;
    end
    else
    begin
      waitRequest_q <= waitRequest_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readData_q <= 32'h0000_0000;
    end
    else
    begin
      readData_q <= readData_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pending_q <= `EXT_IRQ_RST_PENDING;
    end
    else
    begin
      pending_q <= pending_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eventStatus_q <= `EXT_IRQ_RST_EVT_STATUS;
    end
    else
    begin
      eventStatus_q <= eventStatus_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_q <= `EXT_IRQ_RST_CONTROL;
    end
    else
    begin
      control_q <= control_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinSelect_q <= `EXT_IRQ_RST_PIN_SEL;
    end
    else
    begin
      pinSelect_q <= pinSelect_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eventMask_q <= `EXT_IRQ_RST_EVT_MASK;
    end
    else
    begin
      eventMask_q <= eventMask_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      channelRequestFlags <= 8'h00;
    end
    else
    begin
      channelRequestFlags <= pending_d;
    end
  end

  assign readdata = readData_q;
  assign waitrequest = waitRequest_q;
  assign irq = irq_q;

endmodule // ext_irq_edge_detect

// File: ext_irq_defines.svh
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

// Register byte offsets
`define EXT_IRQ_OFS_PENDING 5'h04
`define EXT_IRQ_OFS_CONTROL 5'h08
`define EXT_IRQ_OFS_PIN_SEL 5'h0c
`define EXT_IRQ_OFS_EVT_STATUS 5'h14
`define EXT_IRQ_OFS_EVT_MASK 5'h18
`define EXT_IRQ_OFS_LEVELS 5'h1c

// Reset values
`define EXT_IRQ_RST_PENDING 8'h00
`define EXT_IRQ_RST_CONTROL 32'h0000_0000
`define EXT_IRQ_RST_PIN_SEL 32'h0000_0000
`define EXT_IRQ_RST_EVT_MASK 8'h00
`define EXT_IRQ_RST_EVT_STATUS 8'h00

// Control field layout per channel n: base bit 4n
`define EXT_IRQ_CTL_STRIDE 4
`define EXT_IRQ_CTL_MODE_LSB 0
`define EXT_IRQ_CTL_SAMPLE_BIT 2
`define EXT_IRQ_CTL_FILTER_BIT 3

// Pin select field: port number high nibble, pin number low nibble
`define EXT_IRQ_SEL_WIDTH 8
`define EXT_IRQ_SEL_PORT_MSB 7
`define EXT_IRQ_SEL_PORT_LSB 4
`define EXT_IRQ_SEL_PIN_MSB 3
`define EXT_IRQ_SEL_PIN_LSB 0

// Edge mode codes
`define EXT_IRQ_MODE_OFF 2'h0
`define EXT_IRQ_MODE_FALL 2'h1
`define EXT_IRQ_MODE_RISE 2'h2
`define EXT_IRQ_MODE_BOTH 2'h3

// Noise filter: cycles a new level must stay stable
`define EXT_IRQ_FILTER_CYCLES 4
`define EXT_IRQ_PORT_COUNT 9
`define EXT_IRQ_PINS_PER_PORT 8

`endif

// File: ext_irq_pkg.sv
package ext_irq_pkg;

  typedef enum logic {
    BusIdle,
    BusAnswer
  } bus_state_t;

  typedef logic [1:0] edge_mode_t;

endpackage

// File: ext_irq_channel.sv
`timescale 1ns/100ps
`include "ext_irq_defines.svh"

module ext_irq_channel #(
  parameter int FILTER_CYCLES = `EXT_IRQ_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Input level, already synchronised
  input wire logic levelIn,
  input wire logic samplingTick,
  // Configuration
  input wire logic filterEnable,
  input wire logic samplingEnable,
  input wire ext_irq_pkg::edge_mode_t edgeMode,
  // Result
  output logic edgeDetected
);

  localparam int CNT_W = $clog2(FILTER_CYCLES + 1);

  logic [CNT_W-1:0] stableCnt_q;
  logic filtered_q;
  logic held_q;
  logic pathLevel;
  logic takeSample;
  logic rise;
  logic fall;

  // Digital stand-in for the noise filter: a new level must persist
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stableCnt_q <= '0;
      filtered_q <= 1'b0;
    end
    else if (levelIn == filtered_q)
    begin
      stableCnt_q <= '0;
    end
    else if (stableCnt_q == CNT_W'(FILTER_CYCLES - 1))
    begin
      stableCnt_q <= '0;
      filtered_q <= levelIn;
    end
    else
    begin
      stableCnt_q <= stableCnt_q + CNT_W'(1);
    end
  end

  assign pathLevel = filterEnable ? filtered_q : levelIn;
  assign takeSample = samplingEnable ? samplingTick : 1'b1;

  // Held level tracks the input even with the mode off, so enabling a mode fires no stale edge
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      held_q <= 1'b0;
    end
    else if (takeSample)
    begin
      held_q <= pathLevel;
    end
  end

  assign rise = takeSample & pathLevel & ~held_q;
  assign fall = takeSample & ~pathLevel & held_q;

  always_comb
  begin
    case (edgeMode)
      `EXT_IRQ_MODE_FALL: edgeDetected = fall;
      `EXT_IRQ_MODE_RISE: edgeDetected = rise;
      `EXT_IRQ_MODE_BOTH: edgeDetected = rise | fall;
      default: edgeDetected = 1'b0;
    endcase
  end

endmodule // ext_irq_channel

// File: ext_irq_edge_detect_checker.sv
`timescale 1ns/100ps
module ext_irq_edge_detect_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Requests
  input wire logic [7:0] channelRequestFlags,
  input wire logic irq
);
  wire irqOff = !waitrequest && ((read && address == 5'h14) || (write && address == 5'h18));
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence cfgWrite;
    write && !waitrequest && byteenable == 4'hf && address[4:3] == 2'b01;
  endsequence
  sequence sameRead;
    read && !waitrequest && address == $past(address, 3);
  endsequence
  chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered");
  chk_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  chk_ack_cause: assert property (!waitrequest |-> $past(read) || $past(write))
    else $error("answer without request");
  chk_unmapped_zero: assert property (read && !waitrequest && address == 5'h00 |-> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_flag_readback: assert property (read && !waitrequest && address == 5'h04
    |-> readdata == {24'h00_0000, $past(channelRequestFlags)})
    else $error("flag read differs from flags");
  // A flag may only fall after a one was written to its bit
  chk_flags_sticky: assert property ((|($past(channelRequestFlags) & ~channelRequestFlags))
    |-> $past(write && !waitrequest && address == 5'h04 && byteenable[0])
    && (($past(channelRequestFlags) & ~channelRequestFlags & ~$past(writedata[7:0])) == 8'h00))
    else $error("flag dropped without clear");
  chk_irq_drop: assert property ($fell(irq) |-> $past(irqOff) || $past(irqOff, 2))
    else $error("irq dropped without cause");
  chk_cfg_readback: assert property (cfgWrite ##3 sameRead |-> readdata == $past(writedata, 3))
    else $error("config readback differs");
endmodule // ext_irq_edge_detect_checker

// File: ext_irq_pin_source.sv
`timescale 1ns/100ps
module ext_irq_pin_source (
  // Clock
  input wire logic clk_sys,
  // Command
  input wire logic [6:0] pinIndex,
  input wire logic pinLevel,
  input wire logic pinLoad,
  // Pins
  output logic [71:0] portPins,
  output logic [3:0] upperChannelPins
);
  // Off-chip levels change only on command, so glitch widths are exact
  logic [75:0] levels_q = '0;
  always @(posedge clk_sys)
  begin
    if (pinLoad)
      levels_q[pinIndex] <= pinLevel;
  end
  assign portPins = levels_q[71:0];
  assign upperChannelPins = levels_q[75:72];
endmodule // ext_irq_pin_source

// File: ext_irq_edge_detect_test.sv
`timescale 1ns/100ps
module ext_irq_edge_detect_test;
  logic clk_sys, rst_n, read, write, waitrequest, tick, stopMode, irq, pinLevel, pinLoad;
  logic [4:0] address;
  logic [3:0] byteenable, upperPins;
  logic [31:0] writedata, readdata, rdata, cfg;
  logic [71:0] portPins;
  logic [7:0] flags;
  logic [6:0] pinIndex;
  int nErrors = 0;
  int checked = 0;
  int e;
  ext_irq_edge_detect ext_irq_edge_detect_inst (.clk_sys(clk_sys), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .portPins(portPins), .upperChannelPins(upperPins),
    .lowSpeedSamplingTick(tick), .stopMode(stopMode), .channelRequestFlags(flags), .irq(irq));
  ext_irq_pin_source ext_irq_pin_source_inst (.clk_sys(clk_sys), .pinIndex(pinIndex), .pinLevel(pinLevel),
    .pinLoad(pinLoad), .portPins(portPins), .upperChannelPins(upperPins));
  task automatic report_and_stop();
    if (nErrors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // One idle edge after each transfer keeps two tasks from driving one edge
  task automatic bus(logic wr, logic [4:0] a, logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    byteenable <= 4'hf;
    write <= wr;
    read <= !wr;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rdata = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n == 20)
    begin
      nErrors++;
      report_and_stop();
    end
    @(posedge clk_sys);
  endtask
  task automatic pin(int idx, logic lvl, int hold);
    pinIndex <= 7'(idx);
    pinLevel <= lvl;
    pinLoad <= 1'b1;
    @(posedge clk_sys);
    pinLoad <= 1'b0;
    repeat (hold) @(posedge clk_sys);
  endtask
  task automatic ticks(int k);
    repeat (k)
    begin
      tick <= 1'b1;
      @(posedge clk_sys);
      tick <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
  endtask
  task automatic flagsAre(logic [31:0] exp);
    bus(0, 5'h04, 0);
    check("pending flags", rdata, exp);
    check("flag output", 32'(flags), exp);
  endtask
  // Model of the edge rules: does a mode code fire on a change in this direction
  function automatic int fires(int mode, int rising);
    case (mode)
      1: fires = (rising == 0) ? 1 : 0;
      2: fires = rising;
      3: fires = 1;
      default: fires = 0;
    endcase
  endfunction
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    rst_n = 1'b0;
    {read, write, tick, stopMode, pinLevel, pinLoad} = '0;
    {address, byteenable, writedata, pinIndex} = '0;
    void'($urandom(70369));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a < 32; a += 4)
    begin
      bus(0, 5'(a), 0);
      check("reset value", rdata, 32'h0000_0000);
    end
    bus(1, 5'h10, $urandom);
    bus(0, 5'h10, 0);
    check("unmapped", rdata, 32'h0000_0000);
    for (int i = 0; i < 2; i++)
    begin
      cfg = $urandom;
      bus(1, 5'(8 + 4 * i), cfg);
      bus(0, 5'(8 + 4 * i), 0);
      check("config", rdata, cfg);
    end
    // Channel 0 on port 4 pin 1, channel 7 on its fixed source
    bus(1, 5'h0c, 32'h0000_0041);
    for (int m = 0; m < 4; m++)
    begin
      bus(1, 5'h08, 32'((m << 28) | m));
      bus(1, 5'h04, 32'h0000_00ff);
      for (int lv = 1; lv >= 0; lv--)
      begin
        pin(33, lv[0], 0);
        pin(75, lv[0], 12);
        e = fires(m, lv);
        flagsAre(32'(e * 8'h81));
        bus(1, 5'h04, 32'h0000_00ff);
      end
    end
    pin(33, 1, 0);
    pin(75, 1, 12);
    bus(1, 5'h04, 32'h0000_0000);
    flagsAre(32'h0000_0081);
    bus(1, 5'h04, 32'h0000_0001);
    flagsAre(32'h0000_0080);
    bus(1, 5'h08, 32'h0000_000b);
    pin(33, 1, 12);
    bus(1, 5'h04, 32'h0000_00ff);
    pin(33, 0, 1);
    pin(33, 1, 12);
    flagsAre(32'h0000_0000);
    pin(33, 0, 12);
    flagsAre(32'h0000_0001);
    bus(1, 5'h08, 32'h0000_0006);
    bus(1, 5'h04, 32'h0000_00ff);
    stopMode <= 1'b1;
    pin(33, 1, 12);
    ticks(3);
    flagsAre(32'h0000_0000);
    stopMode <= 1'b0;
    ticks(2);
    flagsAre(32'h0000_0001);
    bus(1, 5'h08, 32'h0000_0003);
    bus(0, 5'h14, 0);
    bus(1, 5'h18, 32'h0000_0001);
    pin(33, 0, 12);
    check("irq raised", irq, 1);
    bus(0, 5'h14, 0);
    check("event status", rdata, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    check("irq cleared", irq, 0);
    bus(1, 5'h18, 32'h0000_0000);
    pin(33, 1, 12);
    check("irq masked", irq, 0);
    bus(0, 5'h14, 0);
    check("masked status", rdata, 32'h0000_0001);
    bus(0, 5'h1c, 0);
    check("levels", rdata, 32'h0000_0081);
    // Reset in mid-run with a flag pending and channels configured
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    check("flags after reset", 32'(flags), 32'h0000_0000);
    bus(0, 5'h08, 0);
    check("control after reset", rdata, 32'h0000_0000);
    flagsAre(32'h0000_0000);
    report_and_stop();
  end
endmodule // ext_irq_edge_detect_test
bind ext_irq_edge_detect ext_irq_edge_detect_checker ext_irq_edge_detect_checker_inst (.clk_sys(clk_sys),
  .rst_n(rst_n), .address(address), .read(read), .write(write), .byteenable(byteenable),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .channelRequestFlags(channelRequestFlags), .irq(irq));
